// *** hdl/pmbaw_params.svh ***
// Purpose: constants for the command-level addressing and write guard
// Assumes: 100 MHz i_clock, byte-wide command data
// Notes: offsets are command codes
`ifndef PMBAW_PARAMS_SVH
`define PMBAW_PARAMS_SVH
`define PMBAW_CMD_PAGE 8'h00
`define PMBAW_CMD_OPERATION 8'h01
`define PMBAW_CMD_ON_OFF 8'h02
`define PMBAW_CMD_CLEAR_FAULTS 8'h03
`define PMBAW_CMD_WP 8'h10
`define PMBAW_CMD_STORE_ALL 8'h15
`define PMBAW_CMD_VOUT 8'h21
`define PMBAW_CMD_STATUS_LO 8'h78
`define PMBAW_CMD_STATUS_HI 8'h80
`define PMBAW_CMD_EE_UNLOCK 8'hBD
`define PMBAW_CMD_PEAK_CLR 8'hE3
`define PMBAW_CMD_CHAN_OPT 8'hD0
`define PMBAW_CMD_SHARED_OPT 8'hD1
`define PMBAW_CMD_CHAN_ADDR 8'hD8
`define PMBAW_CMD_DEV_ADDR 8'hE6
`define PMBAW_CMD_RAIL_ADDR 8'hFA
`define PMBAW_PAGE_CH0 8'h00
`define PMBAW_PAGE_CH1 8'h01
`define PMBAW_PAGE_ALL 8'hFF
`define PMBAW_WP_ALL 8'h80
`define PMBAW_WP_CTRL 8'h40
`define PMBAW_WP_VOUT 8'h20
`define PMBAW_WP_NONE 8'h00
`define PMBAW_ADDR_OFF 8'h80
`define PMBAW_GLOBAL_A 7'h5A
`define PMBAW_GLOBAL_B 7'h5B
`define PMBAW_RST_PAGE 8'h00
`define PMBAW_RST_WP 8'h00
`define PMBAW_RST_CHAN_OPT 8'h1F
`define PMBAW_RST_SHARED_OPT 8'h09
`define PMBAW_RST_CHAN_ADDR 8'h80
`define PMBAW_RST_DEV_ADDR 8'h4F
`define PMBAW_RST_RAIL_ADDR 8'h80
`define PMBAW_OPT_RUN_LOW_DIS 4
`define PMBAW_OPT_SHORT_CYCLE 3
`define PMBAW_OPT_SHARE_CLK 2
`define PMBAW_OPT_NO_GPIO_ALERT 1
`define PMBAW_OPT_NO_DECAY 0
`define PMBAW_SHR_IGNORE_RCFG 6
`define PMBAW_CLK_MHZ 100
`define PMBAW_MINIMUM_OFF_TIME_MS 120
`define PMBAW_MINIMUM_OFF_TIME_CYC (`PMBAW_MINIMUM_OFF_TIME_MS * 1000 * `PMBAW_CLK_MHZ)
`endif

// *** hdl/pmbaw_pkg.sv ***
// Purpose: types for the addressing and write guard block
// Assumes: constants live in pmbaw_params.svh
// Notes: none
package pmbaw_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
    logic use_mask;
    logic [1:0] ch_mask;
  } pmbaw_req_t;
  typedef struct packed {
    logic valid;
    logic ack;
    logic [7:0] rdata;
  } pmbaw_rsp_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
    logic [1:0] ch_mask;
  } pmbaw_fwd_t;
  typedef struct packed {
    logic valid;
    logic dev;
    logic global_hit;
    logic rail;
    logic [1:0] ch_mask;
  } pmbaw_hit_t;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } pmbaw_ara_t;
  typedef enum logic [1:0] {
    PMBAW_SC_IDLE = 2'b00,
    PMBAW_SC_WAIT = 2'b01
  } pmbaw_sc_t;
endpackage

// *** hdl/pmbaw_guard.sv ***
// Purpose: channel select, write lock, slave addressing and channel options
// Assumes: framing, PEC and stretching are done by the bus layer
// Notes: all pins pass a two-stage synchroniser
`timescale 1ns/1ps
`include "pmbaw_params.svh"
module pmbaw_guard #(
  parameter int MINIMUM_OFF_TIME_CYC = `PMBAW_MINIMUM_OFF_TIME_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire pmbaw_pkg::pmbaw_req_t i_req,
  input wire logic i_addr_valid,
  input wire logic [6:0] i_addr,
  input wire logic i_ara_query,
  input wire logic [1:0] i_chan_alert,
  input wire logic i_rail_rd_mismatch,
  input wire logic [1:0] i_off_cmd,
  input wire logic [1:0] i_on_cmd,
  input wire logic [1:0] i_in_toff,
  input wire logic i_wp_pin,
  input wire logic i_address_select_pin_lsb,
  input wire logic i_address_select_pin_open,
  input wire logic [5:0] i_strap_addr,
  input wire logic i_share_clk,
  input wire logic [1:0] i_gpio_low,
  input wire logic [1:0] i_vout_above,
  output pmbaw_pkg::pmbaw_rsp_t o_rsp,
  output pmbaw_pkg::pmbaw_fwd_t o_fwd,
  output pmbaw_pkg::pmbaw_hit_t o_hit,
  output pmbaw_pkg::pmbaw_ara_t o_ara,
  output logic o_comm_fault,
  output logic [1:0] o_run_low_pulse,
  output logic [1:0] o_force_off,
  output logic [1:0] o_turn_on,
  output logic [1:0] o_out_enable,
  output logic [1:0] o_alert_pull,
  output logic [1:0] o_retry_hold
);
  localparam int PW = 14;
  localparam int CW = 24;
  localparam logic [CW-1:0] TOFF_LAST = CW'(MINIMUM_OFF_TIME_CYC - 1);

  // pin synchroniser; stage one feeds stage two only
  logic [PW-1:0] pin_meta_ff;
  logic [PW-1:0] pin_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_meta_ff <= '0;
      pin_ff <= '0;
    end else begin
      pin_meta_ff <= {i_wp_pin, i_address_select_pin_lsb, i_address_select_pin_open, i_strap_addr, i_share_clk, i_gpio_low, i_vout_above};
      pin_ff <= pin_meta_ff;
    end
  end
  wire logic wp_pin = pin_ff[13];
  wire logic address_select_pin_lsb = pin_ff[12];
  wire logic address_select_pin_open = pin_ff[11];
  wire logic [5:0] strap_hi = pin_ff[10:5];
  wire logic share_clk = pin_ff[4];
  wire logic [1:0] gpio_low = pin_ff[3:2];
  wire logic [1:0] vout_above = pin_ff[1:0];

  logic [7:0] page_ff;
  logic [7:0] wp_ff;
  logic [7:0] shared_ff;
  logic [7:0] dev_addr_ff;
  logic [7:0] chan_opt_ff [2];
  logic [7:0] chan_addr_ff [2];
  logic [7:0] rail_addr_ff [2];

  // channel selection
  wire logic [1:0] page_mask =
    (page_ff == `PMBAW_PAGE_CH0) ? 2'h1 :
    (page_ff == `PMBAW_PAGE_CH1) ? 2'h2 :
    (page_ff == `PMBAW_PAGE_ALL) ? 2'h3 : 2'h0;
  wire logic [1:0] sel_mask = i_req.use_mask ? i_req.ch_mask : page_mask;
  wire logic rd_ch = ~sel_mask[0] & sel_mask[1];
  wire logic [7:0] code = i_req.code;
  wire logic [7:0] data = i_req.data;
  wire logic is_paged_local = (code == `PMBAW_CMD_CHAN_OPT) || (code == `PMBAW_CMD_CHAN_ADDR) ||
                              (code == `PMBAW_CMD_RAIL_ADDR);
  wire logic is_local = is_paged_local || (code == `PMBAW_CMD_PAGE) || (code == `PMBAW_CMD_WP) ||
                        (code == `PMBAW_CMD_SHARED_OPT) || (code == `PMBAW_CMD_DEV_ADDR);

  // write lock classes
  wire logic c_wp = code == `PMBAW_CMD_WP;
  wire logic c_page = code == `PMBAW_CMD_PAGE;
  wire logic c_unlock = code == `PMBAW_CMD_EE_UNLOCK;
  wire logic c_store = code == `PMBAW_CMD_STORE_ALL;
  wire logic c_peak = code == `PMBAW_CMD_PEAK_CLR;
  wire logic c_oper = code == `PMBAW_CMD_OPERATION;
  wire logic c_clrf = code == `PMBAW_CMD_CLEAR_FAULTS;
  wire logic c_stat = (code >= `PMBAW_CMD_STATUS_LO) && (code <= `PMBAW_CMD_STATUS_HI);
  wire logic c_vout = (code == `PMBAW_CMD_ON_OFF) || (code == `PMBAW_CMD_VOUT);
  wire logic ok_lvl80 = c_wp | c_page | c_unlock | c_store;
  wire logic ok_lvl40 = ok_lvl80 | c_peak | c_oper | c_clrf | c_stat;
  wire logic ok_lvl20 = ok_lvl40 | c_vout;
  wire logic ok_pin = c_page | c_oper | c_peak | c_unlock | c_clrf | c_stat;
  wire logic ok_reg =
    (wp_ff == `PMBAW_WP_ALL) ? ok_lvl80 :
    (wp_ff == `PMBAW_WP_CTRL) ? ok_lvl40 :
    (wp_ff == `PMBAW_WP_VOUT) ? ok_lvl20 : 1'b1;
  // pin governs unless register sits at the strictest level
  wire logic lock_ok = (wp_pin && (wp_ff != `PMBAW_WP_ALL)) ? ok_pin : ok_reg;

  wire logic addr_val_ok = ~data[7] || (data == `PMBAW_ADDR_OFF);
  wire logic wp_val_ok = (data == `PMBAW_WP_ALL) || (data == `PMBAW_WP_CTRL) ||
                         (data == `PMBAW_WP_VOUT) || (data == `PMBAW_WP_NONE);
  wire logic val_ok = c_wp ? wp_val_ok :
                      ((code == `PMBAW_CMD_DEV_ADDR) || (code == `PMBAW_CMD_CHAN_ADDR) ||
                       (code == `PMBAW_CMD_RAIL_ADDR)) ? addr_val_ok : 1'b1;
  wire logic page_bad = is_paged_local && (sel_mask == 2'h0);
  wire logic wr_acc = i_req.valid && i_req.write && lock_ok && val_ok && !page_bad;
  wire logic rd_acc = i_req.valid && !i_req.write && is_local && !page_bad;
  wire logic wr_local = wr_acc && is_local;
  wire logic clr_faults = wr_acc && c_clrf;

  wire logic [7:0] rd_data =
    c_page ? page_ff :
    c_wp ? wp_ff :
    (code == `PMBAW_CMD_SHARED_OPT) ? shared_ff :
    (code == `PMBAW_CMD_DEV_ADDR) ? dev_addr_ff :
    (code == `PMBAW_CMD_CHAN_OPT) ? chan_opt_ff[rd_ch] :
    (code == `PMBAW_CMD_CHAN_ADDR) ? chan_addr_ff[rd_ch] :
    (code == `PMBAW_CMD_RAIL_ADDR) ? rail_addr_ff[rd_ch] : 8'h00;

  // register file; page 0xFF writes land in both channels
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      page_ff <= `PMBAW_RST_PAGE;
      wp_ff <= `PMBAW_RST_WP;
      shared_ff <= `PMBAW_RST_SHARED_OPT;
      dev_addr_ff <= `PMBAW_RST_DEV_ADDR;
      for (int c = 0; c < 2; c++) begin
        chan_opt_ff[c] <= `PMBAW_RST_CHAN_OPT;
        chan_addr_ff[c] <= `PMBAW_RST_CHAN_ADDR;
        rail_addr_ff[c] <= `PMBAW_RST_RAIL_ADDR;
      end
    end else if (wr_local) begin
      if (c_page) page_ff <= data;
      if (c_wp) wp_ff <= data;
      if (code == `PMBAW_CMD_SHARED_OPT) shared_ff <= data;
      if (code == `PMBAW_CMD_DEV_ADDR) dev_addr_ff <= data;
      for (int c = 0; c < 2; c++) begin
        if (sel_mask[c] && code == `PMBAW_CMD_CHAN_OPT) chan_opt_ff[c] <= data;
        if (sel_mask[c] && code == `PMBAW_CMD_CHAN_ADDR) chan_addr_ff[c] <= data;
        if (sel_mask[c] && code == `PMBAW_CMD_RAIL_ADDR) rail_addr_ff[c] <= data;
      end
    end
  end

  // command answer and forwarding of commands held elsewhere
  pmbaw_pkg::pmbaw_rsp_t rsp_ff;
  pmbaw_pkg::pmbaw_fwd_t fwd_ff;
  wire logic fwd_go = i_req.valid && !is_local && (i_req.write ? wr_acc : 1'b1);
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rsp_ff <= '0;
      fwd_ff <= '0;
    end else begin
      rsp_ff <= '{valid: i_req.valid, ack: wr_acc | rd_acc, rdata: rd_acc ? rd_data : 8'h00};
      fwd_ff <= '{valid: fwd_go, write: i_req.write, code: code, data: data, ch_mask: sel_mask};
    end
  end

  // slave address selection; address_select_pin pin sets lsb unless left open
  wire logic ign_rcfg = shared_ff[`PMBAW_SHR_IGNORE_RCFG];
  wire logic [6:0] dev_eff =
    address_select_pin_open ? dev_addr_ff[6:0] :
    ign_rcfg ? {dev_addr_ff[6:1], address_select_pin_lsb} : {strap_hi, address_select_pin_lsb};
  wire logic dev_on = dev_addr_ff != `PMBAW_ADDR_OFF;
  logic [1:0] chan_hit;
  logic [1:0] rail_hit;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      chan_hit[c] = (chan_addr_ff[c] != `PMBAW_ADDR_OFF) && (chan_addr_ff[c][6:0] == i_addr);
      rail_hit[c] = (rail_addr_ff[c] != `PMBAW_ADDR_OFF) && (rail_addr_ff[c][6:0] == i_addr);
    end
  end
  pmbaw_pkg::pmbaw_hit_t hit_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hit_ff <= '0;
    end else begin
      hit_ff.valid <= i_addr_valid;
      hit_ff.dev <= i_addr_valid && dev_on && (i_addr == dev_eff);
      hit_ff.global_hit <= i_addr_valid && ((i_addr == `PMBAW_GLOBAL_A) || (i_addr == `PMBAW_GLOBAL_B));
      hit_ff.rail <= i_addr_valid && (rail_hit != 2'h0);
      hit_ff.ch_mask <= i_addr_valid ? (chan_hit | rail_hit) : 2'h0;
    end
  end

  // alert response: channel 0 takes priority over channel 1
  wire logic ara_c0 = i_chan_alert[0] && (chan_addr_ff[0] != `PMBAW_ADDR_OFF);
  wire logic ara_c1 = i_chan_alert[1] && (chan_addr_ff[1] != `PMBAW_ADDR_OFF);
  wire logic [6:0] ara_addr = ara_c0 ? chan_addr_ff[0][6:0] : ara_c1 ? chan_addr_ff[1][6:0] : dev_eff;
  pmbaw_pkg::pmbaw_ara_t ara_ff;
  logic comm_fault_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ara_ff <= '0;
      comm_fault_ff <= 1'b0;
    end else begin
      ara_ff <= '{valid: i_ara_query, addr: i_ara_query ? ara_addr : 7'h00};
      // a mismatch in the clearing cycle still latches
      comm_fault_ff <= i_rail_rd_mismatch | (comm_fault_ff & ~clr_faults);
    end
  end

  // per-channel option effects and short-cycle timer
  pmbaw_pkg::pmbaw_sc_t sc_ff [2];
  pmbaw_pkg::pmbaw_sc_t nxt_sc [2];
  logic [CW-1:0] sc_cnt_ff [2];
  logic [CW-1:0] nxt_sc_cnt [2];
  logic [1:0] nxt_force;
  logic [1:0] nxt_on;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      nxt_sc[c] = sc_ff[c];
      nxt_sc_cnt[c] = sc_cnt_ff[c];
      nxt_force[c] = 1'b0;
      nxt_on[c] = 1'b0;
      case (sc_ff[c])
        pmbaw_pkg::PMBAW_SC_IDLE: begin
          if (chan_opt_ff[c][`PMBAW_OPT_SHORT_CYCLE] && i_on_cmd[c] && i_in_toff[c]) begin
            nxt_force[c] = 1'b1;
            nxt_sc[c] = pmbaw_pkg::PMBAW_SC_WAIT;
            nxt_sc_cnt[c] = TOFF_LAST;
          end
        end
        pmbaw_pkg::PMBAW_SC_WAIT: begin
          if (sc_cnt_ff[c] == '0) begin
            nxt_on[c] = 1'b1;
            nxt_sc[c] = pmbaw_pkg::PMBAW_SC_IDLE;
          end else begin
            nxt_sc_cnt[c] = sc_cnt_ff[c] - 1'b1;
          end
        end
        default: nxt_sc[c] = pmbaw_pkg::PMBAW_SC_IDLE;
      endcase
    end
  end

  logic [1:0] run_low_ff;
  logic [1:0] force_ff;
  logic [1:0] on_ff;
  logic [1:0] out_en_ff;
  logic [1:0] alert_ff;
  logic [1:0] retry_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int c = 0; c < 2; c++) begin
        sc_ff[c] <= pmbaw_pkg::PMBAW_SC_IDLE;
        sc_cnt_ff[c] <= '0;
      end
      run_low_ff <= 2'h0;
      force_ff <= 2'h0;
      on_ff <= 2'h0;
      out_en_ff <= 2'h0;
      alert_ff <= 2'h0;
      retry_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        sc_ff[c] <= nxt_sc[c];
        sc_cnt_ff[c] <= nxt_sc_cnt[c];
        run_low_ff[c] <= i_off_cmd[c] && !chan_opt_ff[c][`PMBAW_OPT_RUN_LOW_DIS];
        out_en_ff[c] <= !(chan_opt_ff[c][`PMBAW_OPT_SHARE_CLK] && !share_clk);
        alert_ff[c] <= gpio_low[c] && !chan_opt_ff[c][`PMBAW_OPT_NO_GPIO_ALERT];
        retry_ff[c] <= !chan_opt_ff[c][`PMBAW_OPT_NO_DECAY] && vout_above[c];
      end
      force_ff <= nxt_force;
      on_ff <= nxt_on;
    end
  end

  assign o_rsp = rsp_ff;
  assign o_fwd = fwd_ff;
  assign o_hit = hit_ff;
  assign o_ara = ara_ff;
  assign o_comm_fault = comm_fault_ff;
  assign o_run_low_pulse = run_low_ff;
  assign o_force_off = force_ff;
  assign o_turn_on = on_ff;
  assign o_out_enable = out_en_ff;
  assign o_alert_pull = alert_ff;
  assign o_retry_hold = retry_ff;

  // checks
  lvl80_block_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_ff == 8'h80 && code == 8'h01) |=> (o_rsp.valid && !o_rsp.ack))
    else $error("operation write taken at lock level 0x80");
  lvl40_vout_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_ff == 8'h40 && !wp_pin && code == 8'h21) |=> !o_rsp.ack)
    else $error("voltage write taken at lock level 0x40");
  lvl20_vout_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_ff == 8'h20 && !wp_pin && code == 8'h21) |=> (o_rsp.ack && o_fwd.valid))
    else $error("voltage write refused at lock level 0x20");
  status_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_ff == 8'h40 && code == 8'h7B) |=> o_rsp.ack)
    else $error("status clear refused under lock");
  pin_lock_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_pin && wp_ff != 8'h80 && code == 8'h10) |=> !o_rsp.ack)
    else $error("lock register written while pin high");
  // register at the strictest level outranks the pin
  reg_strict_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_pin && wp_ff == 8'h80 && code == 8'h10) |=> o_rsp.ack)
    else $error("lock register refused at strictest level with pin high");
  lvl00_open_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && i_req.write && wp_ff == 8'h00 && !wp_pin && code == 8'h21) |=> o_rsp.ack)
    else $error("write refused with lock cleared");
  page_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && !i_req.write && !i_req.use_mask && page_ff == 8'hFF && code == 8'hD0)
    |=> (o_rsp.ack && o_rsp.rdata == $past(chan_opt_ff[0])))
    else $error("broadcast read not taken from channel 0");
  rail_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_addr_valid && rail_addr_ff[0] == 8'h80 && rail_addr_ff[1] == 8'h80) |=> !o_hit.rail)
    else $error("disabled rail address answered");
  ara_chan_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_ara_query && i_chan_alert == 2'h1 && chan_addr_ff[0] != 8'h80)
    |=> (o_ara.valid && o_ara.addr == $past(chan_addr_ff[0][6:0])))
    else $error("alert query did not report channel address");
  page_all_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req.valid && !i_req.use_mask && i_req.write && page_ff == 8'hFF && code == 8'hD0 && wr_acc)
    |=> (chan_opt_ff[0] == $past(data) && chan_opt_ff[1] == $past(data)))
    else $error("broadcast write missed a channel");
  dev_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (dev_addr_ff == 8'h80 && i_addr_valid) |=> !o_hit.dev)
    else $error("disabled device address answered");
  global_hit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_addr_valid && i_addr == 7'h5B) |=> o_hit.global_hit)
    else $error("global address missed");
  fault_sticky_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_rail_rd_mismatch |=> o_comm_fault ##1 (o_comm_fault || $past(clr_faults)))
    else $error("rail contention fault not held");
  run_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_off_cmd[0] && chan_opt_ff[0][4]) |=> !o_run_low_pulse[0])
    else $error("run pulsed low though disabled");
  short_cycle_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_force_off[0] |-> (!o_turn_on[0] ##1 (sc_ff[0] == pmbaw_pkg::PMBAW_SC_WAIT)))
    else $error("short cycle did not wait");
  wait_end_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (sc_ff[0] == pmbaw_pkg::PMBAW_SC_WAIT && sc_cnt_ff[0] == '0) |=> (o_turn_on[0] && sc_ff[0] == pmbaw_pkg::PMBAW_SC_IDLE))
    else $error("turn on not issued after minimum off time");
  cov_pin_lock_c: cover property (@(posedge i_clock) disable iff (i_rst) wp_pin && i_req.valid && i_req.write);
  cov_ara_c: cover property (@(posedge i_clock) disable iff (i_rst) i_ara_query && ara_c1);
  cov_short_c: cover property (@(posedge i_clock) disable iff (i_rst) o_turn_on[1]);
  cov_page_all_c: cover property (@(posedge i_clock) disable iff (i_rst) wr_local && page_ff == 8'hFF);
endmodule

// *** tb/pmbaw_host.sv ***
// Purpose: host controller model issuing single-byte command transfers
// Assumes: one request per call, answer registered on the taking edge and read 1 ns later
// Notes: called hierarchically by the bench
`timescale 1ns/1ps
module pmbaw_host (
  input wire logic i_clock,
  output pmbaw_pkg::pmbaw_req_t o_req,
  input wire pmbaw_pkg::pmbaw_rsp_t i_rsp,
  input wire pmbaw_pkg::pmbaw_fwd_t i_fwd
);
  initial o_req = '0;
  // m[2] means sent through a channel or rail address with mask m[1:0]
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d, input logic [2:0] m,
                      output pmbaw_pkg::pmbaw_rsp_t r, output logic fv);
    @(posedge i_clock);
    o_req <= '{valid: 1'b1, write: (w | m[2]), code: c, data: d, use_mask: m[2], ch_mask: m[1:0]};
    @(posedge i_clock);
    o_req.valid <= 1'b0;
    #1;
    r = i_rsp;
    fv = i_fwd.valid;
  endtask
endmodule

// *** tb/tb_pmbus_addressing_write_guard.sv ***
// Purpose: self-checking bench for the addressing and write guard
// Assumes: short minimum off time of 20 cycles
// Notes: pins settle 4 cycles after a change
`timescale 1ns/1ps
`include "pmbaw_params.svh"
module tb_pmbus_addressing_write_guard;
  logic i_clock, i_rst, i_addr_valid, i_ara_query, i_rail_rd_mismatch, i_wp_pin, i_address_select_pin_lsb, i_address_select_pin_open, i_share_clk;
  logic [6:0] i_addr;
  logic [5:0] i_strap_addr;
  logic [1:0] i_chan_alert, i_off_cmd, i_on_cmd, i_in_toff, i_gpio_low, i_vout_above;
  logic [1:0] o_run_low_pulse, o_force_off, o_turn_on, o_out_enable, o_alert_pull, o_retry_hold;
  logic o_comm_fault, fv;
  pmbaw_pkg::pmbaw_req_t i_req;
  pmbaw_pkg::pmbaw_rsp_t o_rsp, r;
  pmbaw_pkg::pmbaw_fwd_t o_fwd;
  pmbaw_pkg::pmbaw_hit_t o_hit, h;
  pmbaw_pkg::pmbaw_ara_t o_ara;
  int errors = 0, cmp_count = 0, cyc = 0, n;
  logic [7:0] cl [11] = '{`PMBAW_CMD_PAGE, `PMBAW_CMD_OPERATION, `PMBAW_CMD_ON_OFF, `PMBAW_CMD_CLEAR_FAULTS,
    `PMBAW_CMD_WP, `PMBAW_CMD_STORE_ALL, `PMBAW_CMD_VOUT, `PMBAW_CMD_STATUS_LO, `PMBAW_CMD_EE_UNLOCK,
    `PMBAW_CMD_PEAK_CLR, `PMBAW_CMD_CHAN_OPT};
  logic [7:0] rc [7] = '{8'h00, 8'h10, 8'hD0, 8'hD1, 8'hD8, 8'hE6, 8'hFA};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h1F, 8'h09, 8'h80, 8'h4F, 8'h80};
  logic [7:0] lv [6] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h00, 8'h80};
  logic [7:0] d, lvl;
  pmbaw_guard #(.MINIMUM_OFF_TIME_CYC(20)) dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req),
    .i_addr_valid(i_addr_valid), .i_addr(i_addr), .i_ara_query(i_ara_query), .i_chan_alert(i_chan_alert),
    .i_rail_rd_mismatch(i_rail_rd_mismatch), .i_off_cmd(i_off_cmd), .i_on_cmd(i_on_cmd), .i_in_toff(i_in_toff),
    .i_wp_pin(i_wp_pin), .i_address_select_pin_lsb(i_address_select_pin_lsb), .i_address_select_pin_open(i_address_select_pin_open), .i_strap_addr(i_strap_addr),
    .i_share_clk(i_share_clk), .i_gpio_low(i_gpio_low), .i_vout_above(i_vout_above), .o_rsp(o_rsp),
    .o_fwd(o_fwd), .o_hit(o_hit), .o_ara(o_ara), .o_comm_fault(o_comm_fault), .o_run_low_pulse(o_run_low_pulse),
    .o_force_off(o_force_off), .o_turn_on(o_turn_on), .o_out_enable(o_out_enable),
    .o_alert_pull(o_alert_pull), .o_retry_hold(o_retry_hold));
  pmbaw_host host_u (.i_clock(i_clock), .o_req(i_req), .i_rsp(o_rsp), .i_fwd(o_fwd));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] dd);
    host_u.xfer(1'b1, c, dd, 3'b000, r, fv);
  endtask
  task automatic probe(input logic [6:0] a);
    @(posedge i_clock);
    i_addr_valid <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_addr_valid <= 1'b0;
    #1;
    h = o_hit;
  endtask
  task automatic settle();
    repeat (4) @(posedge i_clock);
    #1;
  endtask
  function automatic logic allowed(input logic [7:0] l, input logic p, input logic [7:0] c);
    logic st, bs;
    st = (c >= `PMBAW_CMD_STATUS_LO) && (c <= `PMBAW_CMD_STATUS_HI);
    bs = c inside {`PMBAW_CMD_PAGE, `PMBAW_CMD_EE_UNLOCK};
    if (p && l != 8'h80)
      return bs || st || c inside {`PMBAW_CMD_OPERATION, `PMBAW_CMD_PEAK_CLR, `PMBAW_CMD_CLEAR_FAULTS};
    if (l == 8'h80) return bs || c inside {`PMBAW_CMD_WP, `PMBAW_CMD_STORE_ALL};
    if (l == 8'h00) return 1'b1;
    return bs || st || c inside {`PMBAW_CMD_WP, `PMBAW_CMD_STORE_ALL, `PMBAW_CMD_OPERATION,
      `PMBAW_CMD_PEAK_CLR, `PMBAW_CMD_CLEAR_FAULTS} || (l == 8'h20 && c inside {`PMBAW_CMD_ON_OFF, `PMBAW_CMD_VOUT});
  endfunction
  initial begin
    {i_rst, i_addr_valid, i_ara_query, i_rail_rd_mismatch, i_wp_pin, i_address_select_pin_lsb, i_address_select_pin_open} = 7'h40;
    {i_addr, i_strap_addr, i_chan_alert, i_off_cmd, i_on_cmd, i_in_toff, i_gpio_low, i_vout_above} = '0;
    i_share_clk = 1'b1;
    void'($urandom(64229));
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      host_u.xfer(1'b0, rc[k], 8'h00, 3'b000, r, fv);
      chk("reset value", rv[k], r.rdata);
    end
    for (int k = 0; k < 20; k++) begin
      d = 8'($urandom());
      lvl = {7'h00, 1'($urandom())};
      wr(`PMBAW_CMD_PAGE, lvl);
      wr(`PMBAW_CMD_CHAN_OPT, d);
      host_u.xfer(1'b0, `PMBAW_CMD_CHAN_OPT, 8'h00, 3'b000, r, fv);
      chk("paged read", d, r.rdata);
    end
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_ALL);
    wr(`PMBAW_CMD_CHAN_OPT, 8'h5C);
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_CH1);
    host_u.xfer(1'b0, `PMBAW_CMD_CHAN_OPT, 8'h00, 3'b000, r, fv);
    chk("all page ch1", 8'h5C, r.rdata);
    wr(`PMBAW_CMD_CHAN_OPT, 8'h33);
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_ALL);
    host_u.xfer(1'b0, `PMBAW_CMD_CHAN_OPT, 8'h00, 3'b000, r, fv);
    chk("all page read", 8'h5C, r.rdata);
    wr(`PMBAW_CMD_PAGE, 8'h02);
    wr(`PMBAW_CMD_CHAN_OPT, 8'h1F);
    chk("bad page ack", 8'h00, {7'h00, r.ack});
    host_u.xfer(1'b1, `PMBAW_CMD_CHAN_OPT, 8'h1F, 3'b111, r, fv);
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_CH0);
    for (int k = 0; k < 6; k++) begin
      lvl = lv[k];
      i_wp_pin <= 1'b0;
      settle();
      wr(`PMBAW_CMD_WP, lvl);
      chk("lock write", 8'h01, {7'h00, r.ack});
      i_wp_pin <= (k > 3);
      settle();
      for (int j = 0; j < 11; j++) begin
        d = (cl[j] == `PMBAW_CMD_WP) ? lvl : ((cl[j] == `PMBAW_CMD_CHAN_OPT) ? 8'h1F : 8'h00);
        wr(cl[j], d);
        chk("lock ack", {7'h00, allowed(lvl, k > 3, cl[j])}, {7'h00, r.ack});
        chk("lock fwd", {7'h00, r.ack && j != 0 && j != 4 && j != 10}, {7'h00, fv});
      end
    end
    i_wp_pin <= 1'b0;
    settle();
    wr(`PMBAW_CMD_WP, 8'h00);
    i_strap_addr <= 6'h15;
    settle();
    probe(7'h2A);
    chk("strap addr", 8'h01, {7'h00, h.dev});
    wr(`PMBAW_CMD_SHARED_OPT, 8'h49);
    i_address_select_pin_lsb <= 1'b1;
    settle();
    probe(7'h4F);
    chk("ignore cfg", 8'h01, {7'h00, h.dev});
    i_address_select_pin_open <= 1'b1;
    i_address_select_pin_lsb <= 1'b0;
    settle();
    probe(7'h4F);
    chk("open select", 8'h01, {7'h00, h.dev});
    wr(`PMBAW_CMD_DEV_ADDR, `PMBAW_ADDR_OFF);
    probe(7'h4F);
    chk("dev off", 8'h00, {7'h00, h.dev});
    probe(`PMBAW_GLOBAL_A);
    chk("global a", 8'h01, {7'h00, h.global_hit});
    probe(`PMBAW_GLOBAL_B);
    chk("global b", 8'h01, {7'h00, h.global_hit});
    wr(`PMBAW_CMD_DEV_ADDR, 8'h4F);
    wr(`PMBAW_CMD_CHAN_ADDR, 8'h30);
    wr(`PMBAW_CMD_RAIL_ADDR, 8'h40);
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_CH1);
    wr(`PMBAW_CMD_CHAN_ADDR, 8'h31);
    probe(7'h30);
    chk("chan0 hit", 8'h01, {6'h00, h.ch_mask});
    probe(7'h31);
    chk("chan1 hit", 8'h02, {6'h00, h.ch_mask});
    probe(7'h40);
    chk("rail hit", 8'h05, {5'h00, h.rail, h.ch_mask});
    for (int k = 0; k < 3; k++) begin
      i_chan_alert <= 2'(k);
      @(posedge i_clock);
      i_ara_query <= 1'b1;
      @(posedge i_clock);
      i_ara_query <= 1'b0;
      #1;
      chk("ara", (k == 0) ? 8'h4F : 8'h2F + 8'(k), {o_ara.valid, o_ara.addr} ^ 8'h80);
    end
    i_chan_alert <= 2'b00;
    i_rail_rd_mismatch <= 1'b1;
    @(posedge i_clock);
    i_rail_rd_mismatch <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("comm fault", 8'h01, {7'h00, o_comm_fault});
    wr(`PMBAW_CMD_CLEAR_FAULTS, 8'h00);
    @(posedge i_clock);
    #1;
    chk("fault clear", 8'h00, {7'h00, o_comm_fault});
    wr(`PMBAW_CMD_PAGE, `PMBAW_PAGE_CH0);
    for (int k = 0; k < 2; k++) begin
      wr(`PMBAW_CMD_CHAN_OPT, k ? 8'h08 : 8'h1F);
      {i_gpio_low, i_vout_above} <= 4'h5;
      i_share_clk <= 1'b0;
      settle();
      chk("levels", k ? 8'h07 : 8'h00, {5'h00, o_out_enable[0], o_alert_pull[0], o_retry_hold[0]});
      i_share_clk <= 1'b1;
      i_off_cmd <= 2'b01;
      @(posedge i_clock);
      i_off_cmd <= 2'b00;
      #1;
      chk("run pulse", 8'(k), {7'h00, o_run_low_pulse[0]});
    end
    settle();
    chk("share high", 8'h01, {7'h00, o_out_enable[0]});
    i_on_cmd <= 2'b01;
    i_in_toff <= 2'b01;
    @(posedge i_clock);
    {i_on_cmd, i_in_toff} <= 4'h0;
    #1;
    chk("force off", 8'h01, {7'h00, o_force_off[0]});
    n = 0;
    while (o_turn_on[0] !== 1'b1 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk("off time", 8'd20, 8'(n));
    close_out();
  end
endmodule
